//--- core/pss_sram_port.sv
// Host-facing port of a pipelined synchronous burst SRAM with its storage array.
//
// Overview of operation
// - Controller strobe is active low, sampled only at rising clock edges.
// - Accepted controller strobe captures the presented address into address registers.
// - Accepted strobe loads the two lowest address bits as burst start.
// - Both strobes low together with primary select low: processor strobe wins, controller strobe ignored.
// - Sleep high stops accesses and outputs; stored contents are kept.
// - Sleep held low or open; an open pin reads as awake.
// - Data and parity inputs are captured into a register every rising edge.
// - Read data comes from the address taken at the previous rising edge.
// - Output enable low drives data lines; high lets them float.
// - Burst strap low selects linear burst order.
// - Burst strap high or open selects interleaved order, the default.
// - Test serial output changes on the falling edge of the test clock.
// - Processor strobe is ignored while the primary chip select is high.
// - Advance low during a burst steps the burst address that edge.
// - First read clock after deselect keeps data lines undriven.
`timescale 1ns/100ps
module pss_sram_port (
  input  wire logic                         sys_clk,
  input  wire logic                         rst,
  input  wire logic [pss_pkg::ADDR_W-1:0]   addrIn,
  input  wire logic                         controller_addr_strobe_n,
  input  wire logic                         processor_addr_strobe_n,
  input  wire logic                         chip_select_primary_n,
  input  wire logic                         chipSelectSecond,
  input  wire logic                         chipSelectThird_n,
  input  wire logic                         burst_advance_n,
  input  wire logic                         globalWrite_n,
  input  wire logic                         byteWriteEnable_n,
  input  wire logic [pss_pkg::LANES-1:0]    byteWrite_n,
  input  wire logic                         outputEnable_n,
  input  wire logic                         sleep_request,
  input  wire logic                         burstModeStrap,
  input  wire logic [pss_pkg::DATA_W-1:0]   dataIn,
  output logic      [pss_pkg::DATA_W-1:0]   dataOut,
  output logic                              dataOe_n,
  input  wire logic [pss_pkg::PAR_W-1:0]    parity_linesIn,
  output logic      [pss_pkg::PAR_W-1:0]    parity_linesOut,
  output logic                              parity_linesOe_n,
  input  wire logic                         testClk,
  input  wire logic                         testDataIn,
  output logic                              testDataOut,
  output logic                              writeBufReady
);

  // ==========================================================================
  // Asynchronous pin synchronisers
  logic [pss_pkg::ASYNC_W-1:0] syncA_ff;
  logic [pss_pkg::ASYNC_W-1:0] syncB_ff;
  logic                        tckPrev_ff;
  logic                        asleep;
  logic                        interleaved;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      syncA_ff <= '0;
      syncB_ff <= '0;
    end else begin
      syncA_ff <= {testDataIn, testClk, burstModeStrap, sleep_request};
      syncB_ff <= syncA_ff;
    end
  end

  // The pull-down on sleep and pull-up on the strap are resolved on the wire.
  assign asleep      = syncB_ff[pss_pkg::SYN_SLEEP];
  assign interleaved = syncB_ff[pss_pkg::SYN_MODE] != pss_pkg::MODE_LINEAR;

  // ==========================================================================
  // Strobe qualification and burst sequencing
  pss_pkg::pss_bus_e          state_ff;
  logic [pss_pkg::ADDR_W-pss_pkg::BURST_W-1:0] addrHigh_ff;
  logic [pss_pkg::BURST_W-1:0] burstStart_ff;
  logic [pss_pkg::BURST_W-1:0] burstCnt_ff;
  logic [pss_pkg::ADDR_W-1:0] curAddr_ff;
  logic                       rdIssue_ff;
  logic                       wrIssue_ff;
  logic                       firstRead_ff;
  logic [pss_pkg::LANES-1:0]  wrMask_ff;
  logic                       chipSelected;
  logic                       procStrobe;
  logic                       ctrlStrobe;
  logic                       startAcc;
  logic                       deselect;
  logic                       advance;
  logic [pss_pkg::LANES-1:0]  wrMask;
  logic                       writeReq;
  logic [pss_pkg::BURST_W-1:0] nxt_burstCnt;
  logic [pss_pkg::ADDR_W-1:0] nxt_curAddr;

  function automatic logic [pss_pkg::BURST_W-1:0] burstLow(
    input logic [pss_pkg::BURST_W-1:0] startVal,
    input logic [pss_pkg::BURST_W-1:0] cnt,
    input logic                        ilv
  );
    burstLow = ilv ? (startVal ^ cnt) : pss_pkg::BURST_W'(startVal + cnt);
  endfunction : burstLow

  assign chipSelected = !chip_select_primary_n & chipSelectSecond & !chipSelectThird_n;
  // Strobes are only looked at in the clocked logic below, never between edges.
  assign procStrobe = !processor_addr_strobe_n & !chip_select_primary_n & !asleep;
  assign ctrlStrobe = !controller_addr_strobe_n & !procStrobe & !asleep;
  assign startAcc   = (procStrobe | ctrlStrobe) & chipSelected;
  assign deselect   = (procStrobe | ctrlStrobe) & !chipSelected;
  assign advance    = !burst_advance_n & !startAcc & !deselect & !asleep
                      & (state_ff != pss_pkg::ST_DESEL);
  assign wrMask     = !globalWrite_n ? pss_pkg::LANES_ALL :
                      (!byteWriteEnable_n ? ~byteWrite_n : pss_pkg::LANES_NONE);
  // A processor-started access is always a read on its first edge.
  assign writeReq   = (wrMask != pss_pkg::LANES_NONE) & !(startAcc & procStrobe);
  assign nxt_burstCnt = burstCnt_ff + pss_pkg::BURST_ONE;
  assign nxt_curAddr  = startAcc ? addrIn :
                        {addrHigh_ff, burstLow(burstStart_ff, nxt_burstCnt, interleaved)};

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_ff      <= pss_pkg::ST_DESEL;
      addrHigh_ff   <= '0;
      burstStart_ff <= pss_pkg::BURST_ZERO;
      burstCnt_ff   <= pss_pkg::BURST_ZERO;
    end else if (startAcc) begin
      state_ff      <= writeReq ? pss_pkg::ST_WRITE : pss_pkg::ST_READ;
      addrHigh_ff   <= addrIn[pss_pkg::ADDR_W-1:pss_pkg::BURST_W];
      burstStart_ff <= addrIn[pss_pkg::BURST_W-1:0];
      burstCnt_ff   <= pss_pkg::BURST_ZERO;
    end else if (deselect) begin
      state_ff <= pss_pkg::ST_DESEL;
    end else if (advance) begin
      state_ff    <= writeReq ? pss_pkg::ST_WRITE : pss_pkg::ST_READ;
      burstCnt_ff <= nxt_burstCnt;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      curAddr_ff   <= '0;
      rdIssue_ff   <= 1'b0;
      wrIssue_ff   <= 1'b0;
      wrMask_ff    <= pss_pkg::LANES_NONE;
      firstRead_ff <= 1'b0;
    end else begin
      if (startAcc || advance) begin
        curAddr_ff <= nxt_curAddr;
      end
      rdIssue_ff   <= (startAcc | advance) & !writeReq;
      wrIssue_ff   <= (startAcc | advance) & writeReq;
      wrMask_ff    <= wrMask;
      firstRead_ff <= startAcc & !writeReq & (state_ff == pss_pkg::ST_DESEL);
    end
  end

  // ==========================================================================
  // Input data register and write buffer
  logic [pss_pkg::WORD_W-1:0]     pinWord;
  logic [pss_pkg::WORD_W-1:0]     dataIn_ff;
  logic [pss_pkg::WR_ENTRY_W-1:0] bufOut;
  logic                           bufValid;
  logic                           bufReady;
  logic [pss_pkg::ADDR_W-1:0]     drainAddr;
  logic [pss_pkg::LANES-1:0]      drainMask;
  logic [pss_pkg::WORD_W-1:0]     drainWord;
  logic [pss_pkg::WORD_W-1:0]     mergedWord;
  logic [pss_pkg::WORD_W-1:0]     readData_ff;
  logic [pss_pkg::WORD_W-1:0]     mem [0:pss_pkg::MEM_DEPTH-1];

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      dataIn_ff <= '0;
    end else begin
      dataIn_ff <= pinWord;
    end
  end

  // A full buffer drops writeBufReady; the bus partner must hold off writes
  // until it rises, since the pins give no way to stall a burst.
  pss_fifo #(
    .WIDTH (pss_pkg::WR_ENTRY_W),
    .DEPTH (pss_pkg::FIFO_DEPTH)
  ) u_wrbuf (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .inValid  (wrIssue_ff),
    .inReady  (writeBufReady),
    .inData   ({curAddr_ff, wrMask_ff, dataIn_ff}),
    .outValid (bufValid),
    .outReady (bufReady),
    .outData  (bufOut)
  );

  // Draining stops in sleep so the array is left untouched.
  assign bufReady = !asleep;
  assign {drainAddr, drainMask, drainWord} = bufOut;

  genvar lane;
  generate
    for (lane = 0; lane < pss_pkg::LANES; lane++) begin : g_lane
      assign pinWord[lane*pss_pkg::LANE_W +: pss_pkg::LANE_W] =
        {parity_linesIn[lane], dataIn[lane*pss_pkg::LANE_DW +: pss_pkg::LANE_DW]};
      assign mergedWord[lane*pss_pkg::LANE_W +: pss_pkg::LANE_W] = drainMask[lane] ?
        drainWord[lane*pss_pkg::LANE_W +: pss_pkg::LANE_W] :
        mem[drainAddr][lane*pss_pkg::LANE_W +: pss_pkg::LANE_W];
      assign {parity_linesOut[lane], dataOut[lane*pss_pkg::LANE_DW +: pss_pkg::LANE_DW]} =
        readData_ff[lane*pss_pkg::LANE_W +: pss_pkg::LANE_W];
    end
  endgenerate

  // Reads do not look into the buffer, so a read that closely follows a write
  // to the same word may return the old contents.
  always_ff @(posedge sys_clk) begin
    if (bufValid && bufReady) begin
      mem[drainAddr] <= mergedWord;
    end
  end

  // ==========================================================================
  // Pipelined read output and direction control
  logic driveEn_ff;
  logic oeMask_ff;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      readData_ff <= '0;
      driveEn_ff  <= 1'b0;
      oeMask_ff   <= 1'b0;
    end else begin
      if (rdIssue_ff) begin
        readData_ff <= mem[curAddr_ff];
      end
      driveEn_ff <= rdIssue_ff & !asleep;
      oeMask_ff  <= startAcc & !writeReq & (state_ff == pss_pkg::ST_DESEL);
    end
  end

  // Output enable acts without the clock, as on the real pins.
  assign dataOe_n         = !(driveEn_ff & !outputEnable_n & !oeMask_ff & !asleep);
  assign parity_linesOe_n = dataOe_n;

  // ==========================================================================
  // Test serial output
  logic tdiCap_ff;
  logic tdo_ff;
  logic tckRise;
  logic tckFall;

  assign tckRise = syncB_ff[pss_pkg::SYN_TCK] & !tckPrev_ff;
  assign tckFall = !syncB_ff[pss_pkg::SYN_TCK] & tckPrev_ff;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tckPrev_ff <= 1'b0;
      tdiCap_ff  <= 1'b0;
      tdo_ff     <= 1'b0;
    end else begin
      tckPrev_ff <= syncB_ff[pss_pkg::SYN_TCK];
      if (tckRise) begin
        tdiCap_ff <= syncB_ff[pss_pkg::SYN_TDI];
      end
      if (tckFall) begin
        tdo_ff <= tdiCap_ff;
      end
    end
  end

  assign testDataOut = tdo_ff;

  // ==========================================================================
  // Checks
  property p_strobeCapture;
    @(posedge sys_clk) disable iff (rst)
    (startAcc && !procStrobe) |=> (curAddr_ff == $past(addrIn));
  endproperty
  a_strobeCapture: assert property (p_strobeCapture)
    else $error("controller strobe did not capture the address");

  property p_burstLoad;
    @(posedge sys_clk) disable iff (rst)
    startAcc |=> (burstStart_ff == $past(addrIn[pss_pkg::BURST_W-1:0]))
      && (burstCnt_ff == pss_pkg::BURST_ZERO);
  endproperty
  a_burstLoad: assert property (p_burstLoad)
    else $error("burst start not loaded from low address bits");

  property p_procPriority;
    @(posedge sys_clk) disable iff (rst)
    (!processor_addr_strobe_n && !controller_addr_strobe_n && chipSelected && !asleep)
      |=> rdIssue_ff && !wrIssue_ff;
  endproperty
  a_procPriority: assert property (p_procPriority)
    else $error("controller strobe was honoured over processor strobe");

  property p_cs1Ignore;
    @(posedge sys_clk) disable iff (rst)
    (chip_select_primary_n && controller_addr_strobe_n && burst_advance_n)
      |=> !rdIssue_ff && !wrIssue_ff && $stable(state_ff);
  endproperty
  a_cs1Ignore: assert property (p_cs1Ignore)
    else $error("processor strobe acted with primary select high");

  property p_sleepQuiet;
    @(posedge sys_clk) disable iff (rst)
    asleep |=> !rdIssue_ff && !wrIssue_ff ##1 dataOe_n;
  endproperty
  a_sleepQuiet: assert property (p_sleepQuiet)
    else $error("access started during sleep");

  property p_readPipe;
    @(posedge sys_clk) disable iff (rst)
    (rdIssue_ff && !(bufValid && bufReady)) |=> readData_ff == $past(mem[curAddr_ff]);
  endproperty
  a_readPipe: assert property (p_readPipe)
    else $error("read data not from previously addressed word");

  property p_oeFloat;
    @(posedge sys_clk) disable iff (rst)
    outputEnable_n |-> dataOe_n && parity_linesOe_n;
  endproperty
  a_oeFloat: assert property (p_oeFloat)
    else $error("data lines driven with output enable high");

  property p_linear;
    @(posedge sys_clk) disable iff (rst)
    (advance && !interleaved) |=>
      curAddr_ff[1:0] == $past(burstStart_ff) + $past(burstCnt_ff) + 2'h1;
  endproperty
  a_linear: assert property (p_linear)
    else $error("linear burst step wrong");

  property p_interleave;
    @(posedge sys_clk) disable iff (rst)
    (advance && interleaved) |=>
      curAddr_ff[1:0] == ($past(burstStart_ff) ^ ($past(burstCnt_ff) + 2'h1));
  endproperty
  a_interleave: assert property (p_interleave)
    else $error("interleaved burst step wrong");

  property p_advance;
    @(posedge sys_clk) disable iff (rst)
    advance |=> (burstCnt_ff == $past(burstCnt_ff) + 2'h1) && $stable(addrHigh_ff);
  endproperty
  a_advance: assert property (p_advance)
    else $error("advance did not step the burst counter");

  property p_firstMask;
    @(posedge sys_clk) disable iff (rst)
    firstRead_ff |-> dataOe_n;
  endproperty
  a_firstMask: assert property (p_firstMask)
    else $error("data driven on first read clock after deselect");

  property p_tdoFall;
    @(posedge sys_clk) disable iff (rst)
    !tckFall |=> $stable(testDataOut);
  endproperty
  a_tdoFall: assert property (p_tdoFall)
    else $error("test output changed away from a falling test clock");

endmodule : pss_sram_port

//--- core/pss_pkg.sv
// Shared constants and types for the pipelined synchronous SRAM port.
package pss_pkg;

  // ==========================================================================
  // Geometry
  localparam int ADDR_W     = 19;
  localparam int DATA_W     = 32;
  localparam int PAR_W      = 4;
  localparam int LANES      = 4;
  localparam int LANE_DW    = 8;
  localparam int LANE_W     = 9;
  localparam int WORD_W     = 36;
  localparam int BURST_W    = 2;
  localparam int MEM_DEPTH  = 524288;
  localparam int FIFO_DEPTH = 8;
  localparam int WR_ENTRY_W = ADDR_W + LANES + WORD_W;

  // ==========================================================================
  // Asynchronous pin synchroniser slots
  localparam int ASYNC_W    = 4;
  localparam int SYN_SLEEP  = 0;
  localparam int SYN_MODE   = 1;
  localparam int SYN_TCK    = 2;
  localparam int SYN_TDI    = 3;

  // ==========================================================================
  // Strap levels and reset values
  localparam logic               MODE_LINEAR = 1'b0;
  localparam logic [BURST_W-1:0] BURST_ONE   = 2'h1;
  localparam logic [BURST_W-1:0] BURST_ZERO  = 2'h0;
  localparam logic [LANES-1:0]   LANES_ALL   = 4'hf;
  localparam logic [LANES-1:0]   LANES_NONE  = 4'h0;

  typedef enum logic [1:0] {
    ST_DESEL = 2'b00,
    ST_READ  = 2'b01,
    ST_WRITE = 2'b10
  } pss_bus_e;

endpackage : pss_pkg

//--- core/pss_fifo.sv
// Synchronous valid/ready FIFO with parameterised width and depth.
`timescale 1ns/100ps
module pss_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);

  localparam int PTR_W = $clog2(DEPTH);
  localparam logic [PTR_W:0]   CNT_FULL = (PTR_W+1)'(DEPTH);
  localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);

  logic [WIDTH-1:0] slots [0:DEPTH-1];
  logic [PTR_W-1:0] wrPtr_ff;
  logic [PTR_W-1:0] rdPtr_ff;
  logic [PTR_W:0]   count_ff;
  logic             push;
  logic             pop;

  assign inReady  = (count_ff != CNT_FULL);
  assign outValid = (count_ff != '0);
  assign push     = inValid & inReady;
  assign pop      = outValid & outReady;
  assign outData  = slots[rdPtr_ff];

  always_ff @(posedge sys_clk) begin
    if (push) begin
      slots[wrPtr_ff] <= inData;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wrPtr_ff <= '0;
      rdPtr_ff <= '0;
      count_ff <= '0;
    end else begin
      if (push) begin
        wrPtr_ff <= (wrPtr_ff == PTR_LAST) ? '0 : wrPtr_ff + 1'b1;
      end
      if (pop) begin
        rdPtr_ff <= (rdPtr_ff == PTR_LAST) ? '0 : rdPtr_ff + 1'b1;
      end
      if (push && !pop) begin
        count_ff <= count_ff + 1'b1;
      end else if (pop && !push) begin
        count_ff <= count_ff - 1'b1;
      end
    end
  end

endmodule : pss_fifo

//--- tb/pss_bus_model.sv
// Processor-side bus model that drives the SRAM port's synchronous pins.
`timescale 1ns/100ps
module pss_bus_model (
  input  wire logic                       sys_clk,
  input  wire logic [pss_pkg::DATA_W-1:0] dataOut,
  input  wire logic                       dataOe_n,
  input  wire logic [pss_pkg::PAR_W-1:0]  parity_linesOut,
  output logic      [pss_pkg::ADDR_W-1:0] addrIn,
  output logic                            controller_addr_strobe_n,
  output logic                            processor_addr_strobe_n,
  output logic                            chip_select_primary_n,
  output logic                            burst_advance_n,
  output logic                            globalWrite_n,
  output logic      [pss_pkg::DATA_W-1:0] dataIn,
  output logic      [pss_pkg::PAR_W-1:0]  parity_linesIn
);
  logic        drvEn;
  logic [35:0] drvWord;
  logic [35:0] lastWord;
  logic [35:0] pinWord;

  initial begin
    {processor_addr_strobe_n, controller_addr_strobe_n} = 2'h3;
    {chip_select_primary_n, burst_advance_n, globalWrite_n} = 3'h7;
    addrIn = '0;
    drvEn = 1'h0;
    drvWord = '0;
    lastWord = '0;
  end

  // =========================================================================
  // Pin resolution
  // A released bus shows the inverse of its last level, so stale data never passes as valid.
  always_comb begin
    if (drvEn) begin
      pinWord = drvWord;
    end else if (!dataOe_n) begin
      pinWord = {parity_linesOut, dataOut};
    end else begin
      pinWord = ~lastWord;
    end
  end
  assign {parity_linesIn, dataIn} = pinWord;

  always @(negedge sys_clk) begin
    lastWord <= pinWord;
  end

  // =========================================================================
  // One bus cycle: change after a falling edge, hold through the rising edge.
  // Control bits are, from the top: processor strobe, controller strobe,
  // primary select, advance and global write, all active low.
  task automatic cycle(input logic [4:0] ctl, input logic [pss_pkg::ADDR_W-1:0] a,
                       input logic [35:0] w);
    {processor_addr_strobe_n, controller_addr_strobe_n} = ctl[4:3];
    {chip_select_primary_n, burst_advance_n, globalWrite_n} = ctl[2:0];
    addrIn = a;
    drvWord = w;
    drvEn = !ctl[0];
    @(posedge sys_clk);
    @(negedge sys_clk);
  endtask : cycle
endmodule : pss_bus_model

//--- tb/tb.sv
// Self-checking testbench for the pipelined synchronous SRAM port.
`timescale 1ns/100ps
module tb;
  localparam int         AW     = pss_pkg::ADDR_W;
  localparam logic [4:0] C_IDLE = 5'h1b;
  localparam logic [4:0] C_RD   = 5'h13;
  localparam logic [4:0] C_WR   = 5'h12;
  localparam logic [4:0] C_STEP = 5'h19;
  localparam logic [4:0] C_DES  = 5'h17;
  localparam logic [4:0] C_BOTH = 5'h02;
  localparam logic [4:0] C_PCS  = 5'h0f;

  logic                         sys_clk        = 1'h0;
  logic                         rst            = 1'h1;
  logic                         outputEnable_n = 1'h0;
  logic                         sleep_request  = 1'h0;
  logic                         burstModeStrap = 1'h1;
  logic                         testClk        = 1'h0;
  logic                         testDataIn     = 1'h0;
  logic [AW-1:0]                addrIn;
  logic                         ctlStb_n;
  logic                         procStb_n;
  logic                         cs1_n;
  logic                         burstStep_n;
  logic                         gw_n;
  logic [pss_pkg::DATA_W-1:0]   dataIn;
  logic [pss_pkg::DATA_W-1:0]   dataOut;
  logic                         dataOe_n;
  logic [pss_pkg::PAR_W-1:0]    parIn;
  logic [pss_pkg::PAR_W-1:0]    parOut;
  logic                         parOe_n;
  logic                         testDataOut;
  logic                         writeBufReady;
  int                           failures       = 0;
  int                           check_count    = 0;
  int                           cycles         = 0;

  pss_sram_port pss_sram_port_inst (
    .sys_clk(sys_clk), .rst(rst), .addrIn(addrIn),
    .controller_addr_strobe_n(ctlStb_n), .processor_addr_strobe_n(procStb_n),
    .chip_select_primary_n(cs1_n), .chipSelectSecond(1'h1), .chipSelectThird_n(1'h0),
    .burst_advance_n(burstStep_n), .globalWrite_n(gw_n), .byteWriteEnable_n(1'h1),
    .byteWrite_n(4'hf), .outputEnable_n(outputEnable_n), .sleep_request(sleep_request),
    .burstModeStrap(burstModeStrap), .dataIn(dataIn), .dataOut(dataOut),
    .dataOe_n(dataOe_n), .parity_linesIn(parIn), .parity_linesOut(parOut),
    .parity_linesOe_n(parOe_n), .testClk(testClk), .testDataIn(testDataIn),
    .testDataOut(testDataOut), .writeBufReady(writeBufReady)
  );

  pss_bus_model pss_bus_model_inst (
    .sys_clk(sys_clk), .dataOut(dataOut), .dataOe_n(dataOe_n), .parity_linesOut(parOut),
    .addrIn(addrIn), .controller_addr_strobe_n(ctlStb_n),
    .processor_addr_strobe_n(procStb_n), .chip_select_primary_n(cs1_n),
    .burst_advance_n(burstStep_n), .globalWrite_n(gw_n), .dataIn(dataIn),
    .parity_linesIn(parIn)
  );

  always #25 sys_clk = ~sys_clk;

  // =========================================================================
  // Shared helpers
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at time %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // Each address holds a word built from itself, so a wrong address shows at once.
  function automatic logic [35:0] pat(input logic [AW-1:0] a);
    return {a[3:0], 32'h5a00_0000 | 32'(a)};
  endfunction : pat

  function automatic logic [63:0] rdWord();
    return 64'({parOut, dataOut});
  endfunction : rdWord

  task automatic cyc(input logic [4:0] ctl, input logic [AW-1:0] a, input logic [35:0] w);
    pss_bus_model_inst.cycle(ctl, a, w);
  endtask : cyc

  task automatic idle(input int n);
    repeat (n) cyc(C_IDLE, '0, '0);
  endtask : idle

  // =========================================================================
  // Scenarios
  task automatic t_basic();
    logic [AW-1:0] a;
    a = 19'h00100;
    check(64'(writeBufReady), 64'h1);
    cyc(C_WR, a, pat(a));
    idle(3);
    // A controller strobe with the primary select high deselects the device.
    cyc(C_DES, '0, '0);
    cyc(C_RD, a, '0);
    check(64'(dataOe_n), 64'h1);
    idle(1);
    check(rdWord(), 64'(pat(a)));
    check(64'(dataOe_n), 64'h0);
    outputEnable_n = 1'h1;
    cyc(C_RD, a, '0);
    idle(1);
    check(64'(parOe_n), 64'h1);
    outputEnable_n = 1'h0;
    $display("test basic done");
  endtask : t_basic

  task automatic t_burst(input logic ilv);
    logic [AW-1:0] base;
    logic [1:0]    k;
    base = 19'h00200;
    burstModeStrap = ilv;
    idle(4);
    for (int i = 0; i < 4; i++) begin
      cyc(C_WR, base + AW'(i), pat(base + AW'(i)));
    end
    idle(12);
    cyc(C_RD, base + 19'h1, '0);
    for (int i = 0; i < 4; i++) begin
      k = ilv ? (2'h1 ^ 2'(i)) : (2'h1 + 2'(i));
      cyc((i == 3) ? C_IDLE : C_STEP, 19'h7ffff, '0);
      check(rdWord(), 64'(pat(base + AW'(k))));
    end
    $display("test burst mode %0d done", ilv);
  endtask : t_burst

  task automatic t_priority();
    logic [AW-1:0] c;
    c = 19'h00300;
    cyc(C_WR, c, pat(c));
    cyc(C_WR, c + 19'h1, pat(c + 19'h1));
    idle(6);
    cyc(C_BOTH, c, ~pat(c));
    idle(1);
    check(rdWord(), 64'(pat(c)));
    idle(6);
    cyc(C_RD, c, '0);
    idle(1);
    check(rdWord(), 64'(pat(c)));
    cyc(C_PCS, 19'h00200, '0);
    idle(1);
    check(64'(dataOe_n), 64'h1);
    // An ignored strobe must not deselect, so the burst can still step.
    cyc(C_STEP, 19'h7ffff, '0);
    idle(1);
    check(64'(dataOe_n), 64'h0);
    check(rdWord(), 64'(pat(c + 19'h1)));
    $display("test priority done");
  endtask : t_priority

  task automatic t_sleep();
    logic [AW-1:0] c;
    c = 19'h00300;
    sleep_request = 1'h1;
    idle(4);
    cyc(C_WR, c, ~pat(c));
    cyc(C_RD, c, '0);
    idle(1);
    check(64'(dataOe_n), 64'h1);
    sleep_request = 1'h0;
    idle(4);
    cyc(C_RD, c, '0);
    idle(1);
    check(rdWord(), 64'(pat(c)));
    $display("test sleep done");
  endtask : t_sleep

  task automatic t_test_port();
    for (int i = 0; i < 2; i++) begin
      testDataIn = (i == 0);
      testClk = 1'h1;
      idle(10);
      check(64'(testDataOut), 64'(i));
      testClk = 1'h0;
      idle(6);
      check(64'(testDataOut), 64'(i == 0));
    end
    $display("test serial port done");
  endtask : t_test_port

  // =========================================================================
  // Run control
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : final_report

  // The whole run needs about 135 cycles; the ceiling leaves ample room.
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      failures = failures + 1;
      final_report();
    end
  end

  initial begin
    repeat (8) @(posedge sys_clk);
    @(negedge sys_clk);
    rst = 1'h0;
    t_basic();
    t_burst(1'h0);
    t_burst(1'h1);
    t_priority();
    t_sleep();
    t_test_port();
    final_report();
  end
endmodule : tb
